// [hw/slu_lin_tx.sv]
// Operation
// - LIN transmission exists only on channel 2 of serial unit one; other instances get none.
// - Parity is selectable as none, constant zero, even or odd.
// - One or two stop bits follow each character, as configured.
// - Forward output idles high, reverse output inverts the line and idles low.
// - The divider field in data bits 15:9 is taken as at least two, capping the rate at mck/6.
// - The transmit interrupt marks transfer end or buffer empty, per the source select bit.
// - A data write while the buffer is full replaces the pending byte, which is lost.
// - 20 MHz with a /8 operation clock and divider 39 gives 31250 bps; /1 and 31 gives 312500.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slu_lin_tx #(
    parameter int UNIT_ID = 1,
    parameter int CHAN_ID = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [slu_pkg::SLU_ADDR_W-1:0] s_awaddr,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [slu_pkg::SLU_ADDR_W-1:0] s_araddr,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic lin_tx_pin,
    output logic ch2_clock_out,
    output logic irq
);
    import slu_pkg::*;

    logic [15:0] levels_q, out_en_q, mode_q, comm_q;
    logic [6:0] div_q;
    logic [7:0] buf_q;
    logic full_q, op_q;
    logic [1:0] irq_sts_q, irq_mask_q;
    logic aw_full_q, w_full_q;
    logic [7:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    slu_state_e st_q;
    logic phase_q;
    logic [11:0] sh_q;
    logic [3:0] cnt_q;
    logic half_tick;

    // Register write decode
    wire wr_go = aw_full_q && w_full_q && !s_bvalid;
    wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire sel_levels = wr_go && (awaddr_q == SLU_OFF_LEVELS);
    wire sel_out_en = wr_go && (awaddr_q == SLU_OFF_OUT_EN);
    wire sel_start = wr_go && (awaddr_q == SLU_OFF_START);
    wire sel_mode = wr_go && (awaddr_q == SLU_OFF_MODE);
    wire sel_comm = wr_go && (awaddr_q == SLU_OFF_COMM);
    wire sel_data = wr_go && (awaddr_q == SLU_OFF_DATA);
    wire sel_sts = wr_go && (awaddr_q == SLU_OFF_STATUS);
    wire sel_irq_sts = wr_go && (awaddr_q == SLU_OFF_IRQ_STS);
    wire sel_irq_mask = wr_go && (awaddr_q == SLU_OFF_IRQ_MASK);
    wire wr_hit = sel_levels || sel_out_en || sel_start || sel_mode || sel_comm || sel_data
        || sel_sts || sel_irq_sts || sel_irq_mask;
    wire [15:0] levels_d = (levels_q & ~wmask) | (wdata_q & wmask);
    wire [15:0] out_en_d = (out_en_q & ~wmask) | (wdata_q & wmask);
    wire [15:0] mode_d = (mode_q & ~wmask) | (wdata_q & wmask);
    wire [15:0] comm_d = (comm_q & ~wmask) | (wdata_q & wmask);
    wire start_wr = sel_start && wstrb_q[0] && wdata_q[SLU_START_BIT];
    wire buf_wr = sel_data && wstrb_q[0];
    wire [1:0] irq_clr = (sel_irq_sts && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;

    // Mode and frame configuration
    wire [1:0] opmode = mode_q[SLU_MODE_OP_LSB +: 2];
    wire irq_sel_empty = mode_q[SLU_MODE_IRQSEL_BIT];
    wire lin_ok = (UNIT_ID == SLU_LIN_UNIT) && (CHAN_ID == SLU_LIN_CHAN);
    wire uart_mode = (opmode == SLU_OPMODE_UART) && lin_ok;
    wire i2c_mode = (opmode == SLU_OPMODE_I2C);
    wire inv = comm_q[SLU_COMM_INV_BIT];
    wire [1:0] par_sel = comm_q[SLU_COMM_PAR_LSB +: 2];
    wire lsb_first = comm_q[SLU_COMM_LSBF_BIT];
    wire stop2 = comm_q[SLU_COMM_STOP2_BIT];
    wire txen = comm_q[SLU_COMM_TXEN_BIT];
    wire oe_bit = out_en_q[SLU_OE_BIT];
    slu_baud_cfg_s baud_cfg;
    assign baud_cfg.psc = mode_q[SLU_MODE_PSC_LSB +: 4];
    assign baud_cfg.div = div_q;

    // Frame assembly, shifted out bit 0 first
    logic [7:0] rev;
    for (genvar i = 0; i < 8; i++)
    begin : g_rev
        assign rev[i] = buf_q[7-i];
    end
    wire [7:0] ord = lsb_first ? buf_q : rev;
    wire par_en = (par_sel != SLU_PAR_NONE);
    wire par_bit = (par_sel == SLU_PAR_EVEN) ? ^buf_q :
        (par_sel == SLU_PAR_ODD) ? ~^buf_q : 1'b0;
    wire [11:0] uart_frame = par_en ? {2'h3, par_bit, ord, 1'b0} : {3'h7, ord, 1'b0};
    wire [3:0] uart_len = SLU_UART_BASE_LEN + {3'h0, par_en} + {3'h0, stop2};
    wire [11:0] frame = i2c_mode ? {4'hF, rev} : uart_frame;
    wire [3:0] frame_len = i2c_mode ? SLU_I2C_LEN : uart_len;

    // Transmit sequencing
    wire run_ok = op_q && (uart_mode || i2c_mode);
    wire load = ce && (st_q == SLU_IDLE) && run_ok && full_q;
    wire bit_end = (st_q == SLU_SEND) && half_tick && phase_q;
    wire last = bit_end && (cnt_q == 4'h1);
    // Source select is sampled live at each event
    wire ev_tx = (load && irq_sel_empty) || (last && !irq_sel_empty);
    wire ev_lost = ce && buf_wr && full_q && !load;

    slu_baud u_baud (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .restart(load),
        .cfg(baud_cfg),
        .half_tick(half_tick)
    );

    // Write channels, taken in either order, answered after both
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
            s_bvalid <= 1'b0;
            s_bresp <= SLU_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_awvalid && s_awready)
            begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready)
            begin
                w_full_q <= 1'b1;
                wdata_q <= s_wdata[15:0];
                wstrb_q <= s_wstrb[1:0];
                s_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? SLU_RESP_OKAY : SLU_RESP_SLVERR;
            end
            if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // Read channel
    wire [15:0] rd_val =
        (s_araddr == SLU_OFF_LEVELS) ? levels_q :
        (s_araddr == SLU_OFF_OUT_EN) ? out_en_q :
        (s_araddr == SLU_OFF_MODE) ? mode_q :
        (s_araddr == SLU_OFF_COMM) ? comm_q :
        (s_araddr == SLU_OFF_DATA) ? {div_q, 1'b0, buf_q} :
        (s_araddr == SLU_OFF_STATUS) ? {13'h0000, op_q, full_q, st_q == SLU_SEND} :
        (s_araddr == SLU_OFF_IRQ_STS) ? {14'h0000, irq_sts_q} :
        (s_araddr == SLU_OFF_IRQ_MASK) ? {14'h0000, irq_mask_q} : 16'h0000;
    wire rd_hit = (s_araddr <= SLU_OFF_IRQ_MASK) && (s_araddr[1:0] == 2'h0);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= SLU_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_arvalid && s_arready)
            begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= {16'h0000, rd_val};
                s_rresp <= rd_hit ? SLU_RESP_OKAY : SLU_RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            levels_q <= SLU_RST_LEVELS;
            out_en_q <= SLU_RST_ZERO;
            mode_q <= SLU_RST_ZERO;
            comm_q <= SLU_RST_ZERO;
            div_q <= SLU_DIV_MIN;
            irq_mask_q <= 2'h0;
        end
        else if (ce)
        begin
            if (sel_levels)
                levels_q <= levels_d;
            if (sel_out_en)
                out_en_q <= out_en_d;
            if (sel_mode)
                mode_q <= mode_d;
            if (sel_comm)
                comm_q <= comm_d;
            if (sel_data && wstrb_q[1])
                div_q <= wdata_q[SLU_DATA_DIV_LSB +: 7];
            if (sel_irq_mask && wstrb_q[0])
                irq_mask_q <= wdata_q[1:0];
        end
    end

    // Buffer, run state and interrupt flags; a set wins over a clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            buf_q <= 8'h00;
            full_q <= 1'b0;
            op_q <= 1'b0;
            irq_sts_q <= 2'h0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            if (buf_wr)
                buf_q <= wdata_q[7:0];
            full_q <= buf_wr || (full_q && !load);
            op_q <= start_wr || (op_q && txen);
            irq_sts_q <= (irq_sts_q & ~irq_clr) | {ev_lost, ev_tx};
            irq <= |(irq_sts_q & irq_mask_q);
        end
    end

    // Shifter
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= SLU_IDLE;
            phase_q <= 1'b0;
            sh_q <= 12'hFFF;
            cnt_q <= 4'h0;
        end
        else if (ce)
        begin
            unique case (st_q)
                SLU_IDLE:
                begin
                    phase_q <= 1'b0;
                    if (load)
                    begin
                        st_q <= SLU_SEND;
                        sh_q <= frame;
                        cnt_q <= frame_len;
                    end
                end
                SLU_SEND:
                begin
                    if (half_tick)
                        phase_q <= !phase_q;
                    if (last)
                        st_q <= SLU_IDLE;
                    else if (bit_end)
                    begin
                        sh_q <= {1'b1, sh_q[11:1]};
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // Pin drivers
    wire tx_level = (st_q == SLU_SEND) ? (sh_q[0] ^ (inv && uart_mode)) :
        uart_mode ? !inv : levels_q[SLU_LEVEL_DATA_BIT];
    wire pin_d = oe_bit ? tx_level : levels_q[SLU_LEVEL_DATA_BIT];
    wire clk_d = (i2c_mode && (st_q == SLU_SEND)) ? phase_q : levels_q[SLU_LEVEL_CLK_BIT];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lin_tx_pin <= 1'b1;
            ch2_clock_out <= 1'b1;
        end
        else if (ce)
        begin
            lin_tx_pin <= pin_d;
            ch2_clock_out <= clk_d;
        end
    end

    property p_lin_gate;
        @(posedge clk) disable iff (!arst_n)
        (st_q == SLU_IDLE && !lin_ok && !i2c_mode) |=> st_q == SLU_IDLE;
    endproperty
    a_lin_gate: assert property (p_lin_gate)
        else $error("uart frame started on an instance without LIN");

    property p_par_zero;
        @(posedge clk) disable iff (!arst_n)
        (load && uart_mode && par_sel == SLU_PAR_ZERO) |=> !sh_q[9] && cnt_q >= 4'hB;
    endproperty
    a_par_zero: assert property (p_par_zero)
        else $error("zero parity bit not zero");

    property p_stop_len;
        @(posedge clk) disable iff (!arst_n)
        (load && uart_mode) |=> cnt_q == 4'hA + {3'h0, $past(par_en)} + {3'h0, $past(stop2)};
    endproperty
    a_stop_len: assert property (p_stop_len)
        else $error("frame length wrong for stop and parity setting");

    property p_idle_level;
        @(posedge clk) disable iff (!arst_n)
        (ce && st_q == SLU_IDLE && uart_mode && oe_bit) |=> lin_tx_pin == !$past(inv);
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("idle line level does not follow data phase");

    property p_empty_irq;
        @(posedge clk) disable iff (!arst_n)
        (load && irq_sel_empty) |=> irq_sts_q[SLU_IRQ_TX] && full_q == $past(buf_wr)
            ##0 st_q == SLU_SEND;
    endproperty
    a_empty_irq: assert property (p_empty_irq)
        else $error("buffer empty event missing");

    property p_end_irq;
        @(posedge clk) disable iff (!arst_n)
        (last && ce && !irq_sel_empty) |=> irq_sts_q[SLU_IRQ_TX] && st_q == SLU_IDLE;
    endproperty
    a_end_irq: assert property (p_end_irq)
        else $error("transfer end event missing");

    property p_overwrite;
        @(posedge clk) disable iff (!arst_n)
        ev_lost |=> irq_sts_q[SLU_IRQ_LOST] && full_q && buf_q == $past(wdata_q[7:0]);
    endproperty
    a_overwrite: assert property (p_overwrite)
        else $error("pending byte not replaced on overwrite");

    property p_msb_first;
        @(posedge clk) disable iff (!arst_n)
        (load && uart_mode && !lsb_first) |=> sh_q[1] == $past(buf_q[7]) && !sh_q[0];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("msb first order not applied");

    property p_irq_out;
        @(posedge clk) disable iff (!arst_n)
        ce |=> irq == |($past(irq_sts_q) & $past(irq_mask_q));
    endproperty
    a_irq_out: assert property (p_irq_out)
        else $error("interrupt output does not follow masked status");

endmodule : slu_lin_tx
`default_nettype wire

// [hw/slu_pkg.sv]
package slu_pkg;

    // Bus geometry
    localparam int SLU_ADDR_W = 8;
    localparam logic [1:0] SLU_RESP_OKAY = 2'h0;
    localparam logic [1:0] SLU_RESP_SLVERR = 2'h2;

    // Register byte offsets
    localparam logic [7:0] SLU_OFF_LEVELS = 8'h00;
    localparam logic [7:0] SLU_OFF_OUT_EN = 8'h04;
    localparam logic [7:0] SLU_OFF_START = 8'h08;
    localparam logic [7:0] SLU_OFF_MODE = 8'h0C;
    localparam logic [7:0] SLU_OFF_COMM = 8'h10;
    localparam logic [7:0] SLU_OFF_DATA = 8'h14;
    localparam logic [7:0] SLU_OFF_STATUS = 8'h18;
    localparam logic [7:0] SLU_OFF_IRQ_STS = 8'h1C;
    localparam logic [7:0] SLU_OFF_IRQ_MASK = 8'h20;

    // Reset values
    localparam logic [15:0] SLU_RST_LEVELS = 16'h0404;
    localparam logic [15:0] SLU_RST_ZERO = 16'h0000;

    // Output level, output enable and start trigger bits of channel 2
    localparam int SLU_LEVEL_DATA_BIT = 2;
    localparam int SLU_LEVEL_CLK_BIT = 10;
    localparam int SLU_OE_BIT = 2;
    localparam int SLU_START_BIT = 2;

    // Mode configuration fields
    localparam int SLU_MODE_IRQSEL_BIT = 0;
    localparam int SLU_MODE_OP_LSB = 1;
    localparam int SLU_MODE_PSC_LSB = 12;
    localparam logic [1:0] SLU_OPMODE_UART = 2'h1;
    localparam logic [1:0] SLU_OPMODE_I2C = 2'h2;

    // Communication configuration fields
    localparam int SLU_COMM_TXEN_BIT = 15;
    localparam int SLU_COMM_INV_BIT = 13;
    localparam int SLU_COMM_PAR_LSB = 8;
    localparam int SLU_COMM_LSBF_BIT = 7;
    localparam int SLU_COMM_STOP2_BIT = 4;
    localparam logic [1:0] SLU_PAR_NONE = 2'h0;
    localparam logic [1:0] SLU_PAR_ZERO = 2'h1;
    localparam logic [1:0] SLU_PAR_EVEN = 2'h2;
    localparam logic [1:0] SLU_PAR_ODD = 2'h3;

    // Data register fields
    localparam int SLU_DATA_DIV_LSB = 9;
    localparam logic [6:0] SLU_DIV_MIN = 7'h02;

    // Status and interrupt bits
    localparam int SLU_STS_BUSY = 0;
    localparam int SLU_STS_FULL = 1;
    localparam int SLU_STS_OP = 2;
    localparam int SLU_IRQ_TX = 0;
    localparam int SLU_IRQ_LOST = 1;

    // Frame lengths in bit times
    localparam logic [3:0] SLU_UART_BASE_LEN = 4'hA;
    localparam logic [3:0] SLU_I2C_LEN = 4'h9;

    // Unit and channel that carry LIN transmission
    localparam int SLU_LIN_UNIT = 1;
    localparam int SLU_LIN_CHAN = 2;

    typedef struct packed {
        logic [3:0] psc;
        logic [6:0] div;
    } slu_baud_cfg_s;

    typedef enum logic [0:0] {SLU_IDLE, SLU_SEND} slu_state_e;

endpackage : slu_pkg

// [hw/slu_baud.sv]
`timescale 1ns/1ps
`default_nettype none
module slu_baud (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic restart,
    input wire slu_pkg::slu_baud_cfg_s cfg,
    output logic half_tick
);
    import slu_pkg::*;

    logic [15:0] pcnt_q;
    logic [6:0] hcnt_q;
    wire [15:0] plimit = 16'((17'h1 << cfg.psc) - 17'h1);
    wire mck_en = ce && (pcnt_q == plimit);
    wire [6:0] eff_div = (cfg.div < SLU_DIV_MIN) ? SLU_DIV_MIN : cfg.div;

    // Half bit time is eff_div+1 operation clocks, so bit rate is mck/(2*(eff_div+1))
    assign half_tick = mck_en && (hcnt_q == eff_div);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pcnt_q <= 16'h0000;
            hcnt_q <= 7'h00;
        end
        else if (ce)
        begin
            pcnt_q <= (restart || mck_en) ? 16'h0000 : pcnt_q + 16'h0001;
            if (restart || half_tick)
                hcnt_q <= 7'h00;
            else if (mck_en)
                hcnt_q <= hcnt_q + 7'h01;
        end
    end

    property p_rate_floor;
        @(posedge clk) disable iff (!arst_n)
        (half_tick && !restart) |=> (!half_tick || restart) ##1 (!half_tick || $past(restart));
    endproperty
    a_rate_floor: assert property (p_rate_floor)
        else $error("half ticks closer than three operation clocks");

endmodule : slu_baud
`default_nettype wire

// [dv/slu_uart_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module slu_uart_rx_model (
    input wire logic clk,
    input wire logic en,
    input wire logic rx,
    input wire logic inv,
    input wire logic lsbf,
    input wire logic [1:0] par,
    input wire logic stop2,
    input wire logic [15:0] bit_clks,
    output logic [7:0] rx_byte,
    output logic rx_par,
    output logic rx_stop_ok,
    output logic [7:0] rx_count
);
    logic [7:0] sh;
    logic ok;

    initial
    begin
        rx_byte = 8'h00;
        rx_par = 1'b0;
        rx_stop_ok = 1'b0;
        rx_count = 8'h00;
    end

    // Samples every bit in its middle after undoing the phase inversion
    always
    begin
        @(posedge clk);
        if (en && (rx ^ inv) === 1'b0)
        begin
            repeat (bit_clks / 2) @(posedge clk);
            ok = ((rx ^ inv) === 1'b0);
            for (int i = 0; i < 8; i++)
            begin
                repeat (bit_clks) @(posedge clk);
                sh[lsbf ? i : 7 - i] = rx ^ inv;
            end
            if (par != 2'h0)
            begin
                repeat (bit_clks) @(posedge clk);
                rx_par = rx ^ inv;
            end
            repeat (stop2 ? 2 : 1)
            begin
                repeat (bit_clks) @(posedge clk);
                ok = ok && ((rx ^ inv) === 1'b1);
            end
            rx_byte = sh;
            rx_stop_ok = ok;
            rx_count = rx_count + 8'h01;
        end
    end
endmodule : slu_uart_rx_model
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import slu_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic s_awvalid = 1'b0;
    logic s_wvalid = 1'b0;
    logic s_bready = 1'b0;
    logic s_arvalid = 1'b0;
    logic s_rready = 1'b0;
    logic [7:0] s_awaddr = 8'h00;
    logic [7:0] s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'h3;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rsp;
    logic [31:0] s_rdata, rd;
    logic lin_tx_pin, ch2_clock_out, irq, other_pin, rx_par, rx_stop_ok;
    logic m_en = 1'b0;
    logic m_inv = 1'b0;
    logic m_lsbf = 1'b1;
    logic m_stop2 = 1'b0;
    logic [1:0] m_par = 2'h0;
    logic [15:0] m_bit = 16'h6;
    logic [6:0] cur_div = 7'h02;
    logic [7:0] rx_byte, rx_count;
    logic [7:0] seen_cnt = 8'h00;
    int fails = 0;
    int tests_run = 0;
    int other_low = 0;

    always #5 clk = ~clk;

    slu_lin_tx i_dut (.clk, .arst_n, .ce, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
        .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
        .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .lin_tx_pin, .ch2_clock_out, .irq);

    slu_lin_tx #(.UNIT_ID(0), .CHAN_ID(2)) i_dut_other (.clk, .arst_n, .ce, .s_awvalid,
        .s_awready(), .s_awaddr, .s_wvalid, .s_wready(), .s_wdata, .s_wstrb, .s_bvalid(),
        .s_bready, .s_bresp(), .s_arvalid, .s_arready(), .s_araddr, .s_rvalid(), .s_rready,
        .s_rdata(), .s_rresp(), .lin_tx_pin(other_pin), .ch2_clock_out(), .irq());

    slu_uart_rx_model i_rx (.clk, .en(m_en), .rx(lin_tx_pin), .inv(m_inv), .lsbf(m_lsbf),
        .par(m_par), .stop2(m_stop2), .bit_clks(m_bit), .rx_byte, .rx_par, .rx_stop_ok,
        .rx_count);

    // A channel without LIN support must not move its pin during frames
    always @(posedge clk)
        if (m_en && !m_inv && other_pin !== 1'b1)
            other_low <= other_low + 1;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        rsp = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        rd = s_rdata;
        rsp = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_read

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        axi_read(a);
        check(name, rd, e);
    endtask : rchk

    task automatic cfg(input logic [3:0] psc, input logic [6:0] div, input logic [1:0] par,
        input logic inv, input logic lsbf, input logic stop2, input logic isel);
        do axi_read(SLU_OFF_STATUS); while (rd[SLU_STS_BUSY] !== 1'b0);
        m_en <= 1'b0;
        cur_div = div;
        axi_write(SLU_OFF_MODE, {16'h0, psc, 9'h0, SLU_OPMODE_UART, isel});
        axi_write(SLU_OFF_COMM, {16'h0, 2'h2, inv, 3'h0, par, lsbf, 2'h0, stop2, 4'h0});
        axi_write(SLU_OFF_OUT_EN, 32'h4);
        axi_write(SLU_OFF_START, 32'h4);
        m_par <= par;
        m_inv <= inv;
        m_lsbf <= lsbf;
        m_stop2 <= stop2;
        m_bit <= 16'(2 * ((div < 7'h02 ? 7'h02 : div) + 1)) << psc;
        m_en <= 1'b1;
    endtask : cfg

    task automatic put(input logic [7:0] b);
        axi_write(SLU_OFF_DATA, {16'h0, cur_div, 1'b0, b});
    endtask : put

    task automatic expect_rx(input logic [7:0] b);
        int n;
        n = 0;
        while (rx_count === seen_cnt && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000)
            fails++;
        seen_cnt = seen_cnt + 8'h01;
        check("rx data", 32'(rx_byte), 32'(b));
        check("rx stop", 32'(rx_stop_ok), 32'h1);
        if (m_par != SLU_PAR_NONE)
            check("rx parity", 32'(rx_par), 32'((m_par != SLU_PAR_ZERO) &
                ((^b) ^ (m_par == SLU_PAR_ODD))));
    endtask : expect_rx

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        check("pin idle", 32'({lin_tx_pin, irq}), 32'h2);
        rchk("levels", SLU_OFF_LEVELS, 32'h404);
        rchk("divider", SLU_OFF_DATA, 32'h400);
        rchk("status", SLU_OFF_STATUS, 32'h0);
        axi_read(8'h40);
        check("unmapped read", 32'(rsp), 32'(SLU_RESP_SLVERR));
        axi_write(8'h44, 32'hFFFF);
        check("unmapped write", 32'(rsp), 32'(SLU_RESP_SLVERR));
        axi_write(SLU_OFF_LEVELS, 32'h0);
        rchk("levels low", SLU_OFF_LEVELS, 32'h0);
        check("start levels", 32'({lin_tx_pin, ch2_clock_out}), 32'h0);
        axi_write(SLU_OFF_LEVELS, 32'h404);
        axi_read(SLU_OFF_LEVELS);
        check("idle levels", 32'({lin_tx_pin, ch2_clock_out}), 32'h3);
        for (int i = 0; i < 4; i++)
        begin
            cfg(4'h0, 7'(i), 2'(i), i[0], i[1], i[0], 1'b0);
            put(8'hA5 + 8'(i * 16));
            expect_rx(8'hA5 + 8'(i * 16));
        end
        // Divider 39 over 8 and divider 31 undivided give the two exact rates
        cfg(4'h3, 7'h27, SLU_PAR_EVEN, 1'b0, 1'b1, 1'b0, 1'b0);
        put(8'h96);
        expect_rx(8'h96);
        cfg(4'h0, 7'h1F, SLU_PAR_ODD, 1'b1, 1'b0, 1'b1, 1'b0);
        put(8'h69);
        expect_rx(8'h69);
        axi_write(SLU_OFF_IRQ_MASK, 32'h1);
        cfg(4'h0, 7'h02, SLU_PAR_ODD, 1'b0, 1'b1, 1'b0, 1'b0);
        axi_write(SLU_OFF_IRQ_STS, 32'h3);
        put(8'h81);
        rchk("end event early", SLU_OFF_IRQ_STS, 32'h0);
        expect_rx(8'h81);
        for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
        rchk("end event", SLU_OFF_IRQ_STS, 32'h1);
        check("irq high", 32'(irq), 32'h1);
        axi_write(SLU_OFF_IRQ_STS, 32'h1);
        rchk("cleared", SLU_OFF_IRQ_STS, 32'h0);
        check("irq low", 32'(irq), 32'h0);
        cfg(4'h0, 7'h02, SLU_PAR_NONE, 1'b0, 1'b0, 1'b1, 1'b1);
        axi_write(SLU_OFF_IRQ_STS, 32'h3);
        put(8'hC3);
        put(8'h3C);
        rchk("buffer full", SLU_OFF_STATUS, 32'h7);
        rchk("empty event", SLU_OFF_IRQ_STS, 32'h1);
        put(8'h5A);
        rchk("overwrite", SLU_OFF_IRQ_STS, 32'h3);
        check("irq unmasked", 32'(irq), 32'h1);
        axi_write(SLU_OFF_IRQ_MASK, 32'h0);
        axi_read(SLU_OFF_STATUS);
        check("irq masked", 32'(irq), 32'h0);
        expect_rx(8'hC3);
        // Switch to transfer-end events just after 0xC3 has ended and the last byte 0x5A has already been loaded from the buffer
        axi_write(SLU_OFF_MODE, {16'h0, 4'h0, 9'h0, SLU_OPMODE_UART, 1'b0});
        axi_write(SLU_OFF_IRQ_STS, 32'h3);
        expect_rx(8'h5A);
        repeat (8) @(posedge clk);
        rchk("switched source", SLU_OFF_IRQ_STS, 32'h1);
        check("other channel", 32'(other_low), 32'h0);
        // Simple I2C address byte: its first bit is low, so the receiver takes it as a start
        cfg(4'h0, 7'h02, SLU_PAR_NONE, 1'b0, 1'b0, 1'b0, 1'b0);
        axi_write(SLU_OFF_MODE, {16'h0, 4'h0, 9'h0, SLU_OPMODE_I2C, 1'b0});
        put(8'h34);
        expect_rx(8'h69);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
